// ===== hw/boag_pkg.sv
// branch and operand address generator: shared constants and carriers
// assumes one 20 MHz core clock and a 64 KiB flat memory space
package boag_pkg;

    // ******************************************************************
    // address map
    // ******************************************************************
    localparam logic [15:0] CALL_TABLE_BASE = 16'h0040;
    localparam logic [15:0] CALL_TABLE_LAST = 16'h007F;
    localparam logic [15:0] SHORT_BASE = 16'hFE20;
    localparam logic [15:0] SHORT_LAST = 16'hFF1F;
    localparam logic [15:0] SHORT_RAM_LAST = 16'hFEFF;
    localparam logic [15:0] SFR_BASE = 16'hFF00;
    localparam logic [15:0] SFR_GAP_FIRST = 16'hFFD0;
    localparam logic [15:0] SFR_GAP_LAST = 16'hFFDF;
    localparam logic [15:0] RAM_FIRST = 16'hFE20;
    localparam logic [15:0] RAM_LAST = 16'hFEFF;
    localparam logic [7:0] SHORT_HIGH_SPLIT = 8'h20;
    localparam logic [6:0] SHORT_TOP_BITS = 7'h7F;
    localparam int TABLE_SEL_LSB = 1;
    localparam int TABLE_SEL_MSB = 5;
    localparam logic [7:0] OPC_PUSH_DEST = 8'hAA;
    localparam logic [15:0] SP_RESET = 16'hFEFF;
    localparam logic [15:0] PC_RESET = 16'h0000;

    // ******************************************************************
    // kinds of request
    // ******************************************************************
    typedef enum logic [2:0] {
        BR_NONE = 3'h0,
        BR_IMM = 3'h1,
        BR_TABLE = 3'h2,
        BR_ACC_PAIR = 3'h3
    } boag_branch_e;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_DIRECT = 4'h1,
        OP_SHORT = 4'h2,
        OP_SFR = 4'h3,
        OP_REG = 4'h4,
        OP_IND_DEST = 4'h5,
        OP_IND_BASE = 4'h6,
        OP_BASED = 4'h7,
        OP_PUSH = 4'h8,
        OP_POP = 4'h9
    } boag_mode_e;

    typedef enum logic [1:0] {
        TS_IDLE = 2'h0,
        TS_LOW = 2'h1,
        TS_HIGH = 2'h2
    } boag_tstate_e;

    typedef struct packed {
        boag_branch_e branch;
        boag_mode_e mode;
        logic [7:0] opcode;
        logic [15:0] imm16;
        logic [7:0] imm8;
        logic [2:0] reg_code;
        logic wide;
    } boag_req_s;

    typedef struct packed {
        logic [15:0] accumulator_pair;
        logic [15:0] destination_pair;
        logic [15:0] base_pair;
    } boag_pairs_s;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic wide;
        logic is_reg;
        logic [2:0] reg_sel;
        logic in_ram;
        logic in_sfr;
        logic fault;
    } boag_opnd_s;

endpackage

// ===== hw/boag_short_map.sv
// short-direct and special-register address forming
// assumes a purely combinational caller
`timescale 1ns/100ps
`default_nettype none
module boag_short_map (
    input wire logic [7:0] field,
    input wire logic sfr_mode,
    output logic [15:0] addr,
    output logic in_ram,
    output logic in_sfr,
    output logic sfr_hole
);
    always_comb begin
        if (sfr_mode) begin
            addr = boag_pkg::SFR_BASE | {8'h00, field};
        end else begin
            addr = {boag_pkg::SHORT_TOP_BITS, (field < boag_pkg::SHORT_HIGH_SPLIT), field};
        end
        in_ram = (addr >= boag_pkg::RAM_FIRST) && (addr <= boag_pkg::SHORT_RAM_LAST);
        in_sfr = addr >= boag_pkg::SFR_BASE;
        // the unused hole inside the sfr page is flagged, not remapped
        sfr_hole = sfr_mode && (addr >= boag_pkg::SFR_GAP_FIRST)
            && (addr <= boag_pkg::SFR_GAP_LAST);
    end
endmodule
`default_nettype wire

// ===== hw/boag_stack.sv
// stack pointer with push and pop addressing
// assumes at most one push or pop request per cycle
`timescale 1ns/100ps
`default_nettype none
module boag_stack (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic push,
    input wire logic pop,
    input wire logic sp_load,
    input wire logic [15:0] sp_value,
    output logic [15:0] stack_pointer,
    output logic [15:0] stack_addr
);
    logic [15:0] sp_q, sp_d;

    always_comb begin
        sp_d = sp_q;
        stack_addr = sp_q;
        if (sp_load) begin
            sp_d = sp_value;
        end else if (push) begin
            // pre-decrement for a word: the address is the new pointer
            sp_d = sp_q - 16'h0002;
            stack_addr = sp_d;
        end else if (pop) begin
            sp_d = sp_q + 16'h0002;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sp_q <= boag_pkg::SP_RESET;
        end else begin
            sp_q <= sp_d;
        end
    end

    assign stack_pointer = sp_q;
endmodule
`default_nettype wire

// ===== hw/boag_top.sv
// branch target and operand address generator of the 8-bit core
// assumes requests are single-cycle pulses from decode and that the
// memory bus answers a table read in the same cycle as its strobe
`timescale 1ns/100ps
`default_nettype none
module boag_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire boag_pkg::boag_req_s req,
    input wire boag_pkg::boag_pairs_s pairs,
    input wire logic sp_load,
    input wire logic [15:0] sp_value,
    input wire logic irq_save,
    input wire logic irq_restore,
    output logic busy,
    output logic table_rd,
    output logic [15:0] table_addr,
    input wire logic [7:0] table_data,
    output logic pc_load,
    output logic [15:0] pc_target,
    output boag_pkg::boag_opnd_s opnd,
    output logic [15:0] stack_pointer
);

    // ******************************************************************
    // helpers
    // ******************************************************************
    function automatic logic [15:0] zext8(input logic [7:0] v);
        zext8 = {8'h00, v};
    endfunction

    function automatic logic [15:0] table_entry(input logic [7:0] opc);
        logic [4:0] sel;
        sel = opc[boag_pkg::TABLE_SEL_MSB:boag_pkg::TABLE_SEL_LSB];
        table_entry = boag_pkg::CALL_TABLE_BASE + {10'h000, sel, 1'b0};
    endfunction

    logic take;
    logic is_push;
    logic is_pop;
    logic [15:0] stack_addr;
    logic [15:0] short_addr;
    logic short_ram;
    logic short_sfr;
    logic sfr_hole;

    assign take = req_valid && !busy;

    assign is_push = take && ((req.mode == boag_pkg::OP_PUSH)
        || (req.opcode == boag_pkg::OPC_PUSH_DEST)) || irq_save;
    assign is_pop = (take && (req.mode == boag_pkg::OP_POP)) || irq_restore;

    boag_short_map u_short (
        .field(req.imm8),
        .sfr_mode(req.mode == boag_pkg::OP_SFR),
        .addr(short_addr),
        .in_ram(short_ram),
        .in_sfr(short_sfr),
        .sfr_hole(sfr_hole)
    );

    boag_stack u_stack (
        .clk(clk),
        .sys_rst(sys_rst),
        .push(is_push),
        .pop(is_pop),
        .sp_load(sp_load),
        .sp_value(sp_value),
        .stack_pointer(stack_pointer),
        .stack_addr(stack_addr)
    );

    // ******************************************************************
    // branch target sequencer
    // ******************************************************************
    boag_pkg::boag_tstate_e ts_q, ts_d;
    logic [15:0] tptr_q, tptr_d;
    logic [7:0] tlow_q, tlow_d;
    logic pc_load_q, pc_load_d;
    logic [15:0] pc_q, pc_d;

    always_comb begin
        ts_d = ts_q;
        tptr_d = tptr_q;
        tlow_d = tlow_q;
        pc_load_d = 1'b0;
        pc_d = pc_q;
        unique case (ts_q)
            boag_pkg::TS_IDLE: begin
                if (take) begin
                    unique case (req.branch)
                        boag_pkg::BR_IMM: begin
                            pc_d = req.imm16;
                            pc_load_d = 1'b1;
                        end
                        boag_pkg::BR_TABLE: begin
                            tptr_d = table_entry(req.opcode);
                            ts_d = boag_pkg::TS_LOW;
                        end
                        boag_pkg::BR_ACC_PAIR: begin
                            pc_d = pairs.accumulator_pair;
                            pc_load_d = 1'b1;
                        end
                        default: begin
                            pc_d = pc_q;
                        end
                    endcase
                end
            end
            boag_pkg::TS_LOW: begin
                tlow_d = table_data;
                tptr_d = tptr_q + 16'h0001;
                ts_d = boag_pkg::TS_HIGH;
            end
            boag_pkg::TS_HIGH: begin
                pc_d = {table_data, tlow_q};
                pc_load_d = 1'b1;
                ts_d = boag_pkg::TS_IDLE;
            end
            default: begin
                ts_d = boag_pkg::TS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ts_q <= boag_pkg::TS_IDLE;
            tptr_q <= 16'h0000;
            tlow_q <= 8'h00;
            pc_load_q <= 1'b0;
            pc_q <= boag_pkg::PC_RESET;
        end else begin
            ts_q <= ts_d;
            tptr_q <= tptr_d;
            tlow_q <= tlow_d;
            pc_load_q <= pc_load_d;
            pc_q <= pc_d;
        end
    end

    // table is read in two back-to-back cycles; decode waits meanwhile
    assign busy = ts_q != boag_pkg::TS_IDLE;
    assign table_rd = (ts_q == boag_pkg::TS_LOW) || (ts_q == boag_pkg::TS_HIGH);
    assign table_addr = tptr_q;
    assign pc_load = pc_load_q;
    assign pc_target = pc_q;

    // ******************************************************************
    // operand address
    // ******************************************************************
    boag_pkg::boag_opnd_s op_q, op_d;

    always_comb begin
        op_d = '0;
        op_d.wide = req.wide;
        if (take) begin
            op_d.valid = 1'b1;
            unique case (req.mode)
                boag_pkg::OP_DIRECT: begin
                    op_d.addr = req.imm16;
                end
                boag_pkg::OP_SHORT, boag_pkg::OP_SFR: begin
                    op_d.addr = short_addr;
                    op_d.in_ram = short_ram;
                    op_d.in_sfr = short_sfr;
                    op_d.fault = sfr_hole
                        || (req.wide && (req.mode == boag_pkg::OP_SFR));
                end
                boag_pkg::OP_REG: begin
                    op_d.is_reg = 1'b1;
                    op_d.reg_sel = req.wide ? {req.reg_code[1:0], 1'b0} : req.reg_code;
                end
                boag_pkg::OP_IND_DEST: begin
                    op_d.addr = pairs.destination_pair;
                end
                boag_pkg::OP_IND_BASE: begin
                    op_d.addr = pairs.base_pair;
                end
                boag_pkg::OP_BASED: begin
                    op_d.addr = pairs.base_pair + zext8(req.imm8);
                end
                boag_pkg::OP_PUSH, boag_pkg::OP_POP: begin
                    op_d.addr = stack_addr;
                    op_d.wide = 1'b1;
                    op_d.in_ram = 1'b1;
                end
                default: begin
                    op_d.valid = (req.opcode == boag_pkg::OPC_PUSH_DEST);
                    op_d.addr = stack_addr;
                    op_d.wide = op_d.valid;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            op_q <= '0;
        end else begin
            op_q <= op_d;
        end
    end

    assign opnd = op_q;

    // ******************************************************************
    // checks
    // ******************************************************************
    chk_imm_branch: assert property (@(posedge clk) disable iff (sys_rst)
        take && req.branch == boag_pkg::BR_IMM |=> pc_load && pc_target == $past(req.imm16))
        else $error("immediate branch target wrong");
    chk_table_addr: assert property (@(posedge clk) disable iff (sys_rst)
        take && req.branch == boag_pkg::BR_TABLE |=> table_rd
        && table_addr >= boag_pkg::CALL_TABLE_BASE && table_addr <= boag_pkg::CALL_TABLE_LAST)
        else $error("table address out of table");
    chk_table_pair: assert property (@(posedge clk) disable iff (sys_rst)
        ts_q == boag_pkg::TS_LOW |=> table_addr == $past(table_addr) + 16'h0001
        ##1 pc_load && pc_target == {$past(table_data), $past(table_data, 2)})
        else $error("table entry byte order wrong");
    chk_acc_branch: assert property (@(posedge clk) disable iff (sys_rst)
        take && req.branch == boag_pkg::BR_ACC_PAIR
        |=> pc_target == $past(pairs.accumulator_pair))
        else $error("register branch target wrong");
    chk_direct_addr: assert property (@(posedge clk) disable iff (sys_rst)
        take && req.mode == boag_pkg::OP_DIRECT |=> opnd.addr == $past(req.imm16))
        else $error("direct address modified");
    chk_short_window: assert property (@(posedge clk) disable iff (sys_rst)
        take && req.mode == boag_pkg::OP_SHORT |=> opnd.addr >= boag_pkg::SHORT_BASE
        && opnd.addr <= boag_pkg::SHORT_LAST && opnd.addr[7:0] == $past(req.imm8))
        else $error("short address outside window");
    chk_sfr_page: assert property (@(posedge clk) disable iff (sys_rst)
        take && req.mode == boag_pkg::OP_SFR |=> opnd.addr[15:8] == 8'hFF)
        else $error("sfr address off page");
    chk_based_sum: assert property (@(posedge clk) disable iff (sys_rst)
        take && req.mode == boag_pkg::OP_BASED
        |=> opnd.addr == 16'($past(pairs.base_pair) + {8'h00, $past(req.imm8)}))
        else $error("based address wrong");
    chk_push_sp: assert property (@(posedge clk) disable iff (sys_rst)
        take && req.opcode == boag_pkg::OPC_PUSH_DEST && !sp_load
        |=> stack_pointer == $past(stack_pointer) - 16'h0002)
        else $error("push did not lower pointer");
    chk_word_sfr: assert property (@(posedge clk) disable iff (sys_rst)
        take && req.mode == boag_pkg::OP_SFR && req.wide |=> opnd.fault)
        else $error("word sfr access not faulted");
    chk_reg_select: assert property (@(posedge clk) disable iff (sys_rst)
        take && req.mode == boag_pkg::OP_REG
        |=> opnd.is_reg
        && (opnd.wide ? !opnd.reg_sel[0] : opnd.reg_sel == $past(req.reg_code)))
        else $error("register select wrong");
    chk_ind_pointer: assert property (@(posedge clk) disable iff (sys_rst)
        take && (req.mode == boag_pkg::OP_IND_DEST || req.mode == boag_pkg::OP_IND_BASE)
        |=> opnd.addr == ($past(req.mode) == boag_pkg::OP_IND_DEST
        ? $past(pairs.destination_pair) : $past(pairs.base_pair)))
        else $error("indirect address wrong");
    chk_short_split: assert property (@(posedge clk) disable iff (sys_rst)
        take && req.mode == boag_pkg::OP_SHORT
        |=> opnd.in_ram == ($past(req.imm8) >= boag_pkg::SHORT_HIGH_SPLIT)
        && opnd.in_sfr == !opnd.in_ram)
        else $error("short window split wrong");
    chk_pop_stack: assert property (@(posedge clk) disable iff (sys_rst)
        take && req.mode == boag_pkg::OP_POP && req.opcode != boag_pkg::OPC_PUSH_DEST
        && !sp_load && !irq_save
        |=> opnd.addr == $past(stack_pointer)
        && stack_pointer == $past(stack_pointer) + 16'h0002)
        else $error("pop stack address wrong");

    cov_table_call: cover property (@(posedge clk) disable iff (sys_rst)
        take && req.branch == boag_pkg::BR_TABLE ##3 pc_load);
    cov_short_sfr: cover property (@(posedge clk) disable iff (sys_rst)
        opnd.valid && opnd.in_sfr);
    cov_based_wrap: cover property (@(posedge clk) disable iff (sys_rst)
        take && req.mode == boag_pkg::OP_BASED && pairs.base_pair == 16'hFFFF);
endmodule
`default_nettype wire

// ===== testbench/boag_mem_model.sv
// call-table memory seen by the table read port of the address generator
// assumes one bench clock and reads answered in the same cycle
`timescale 1ns/100ps
`default_nettype none
module boag_mem_model (
    input wire logic clk,
    input wire logic table_rd,
    input wire logic [15:0] table_addr,
    output logic [7:0] table_data
);
    logic [7:0] last_q = 8'h00;

    // low byte even
    // entry n reads as {3'b101, n, n, 3'b011}; the released bus shows the
    // inverse of the last byte so a late sample never passes by luck
    always_comb begin
        if (!table_rd) begin
            table_data = ~last_q;
        end else if (table_addr[0]) begin
            table_data = {3'b101, table_addr[5:1]};
        end else begin
            table_data = {table_addr[5:1], 3'b011};
        end
    end

    always @(posedge clk) begin
        if (table_rd) begin
            last_q <= table_data;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// self-checking bench for the branch and operand address generator
// assumes a call-table model on the table port and a 50 ns clock
`timescale 1ns/100ps
`default_nettype none
module testbench;
    typedef struct {
        logic [2:0] br;
        logic [3:0] md;
        logic [15:0] i16;
        logic [7:0] i8;
        logic [2:0] code;
        logic wide;
        int kind;
        logic [15:0] exp;
        logic [2:0] flg;
    } boag_row_s;

    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic req_valid = 1'b0;
    boag_pkg::boag_req_s req = '0;
    boag_pkg::boag_pairs_s pairs = {16'h1234, 16'hFE40, 16'hFFF0};
    logic sp_load = 1'b0;
    logic [15:0] sp_value = 16'hFE80;
    logic irq_save = 1'b0;
    logic irq_restore = 1'b0;
    logic busy, table_rd, pc_load;
    logic [15:0] table_addr, pc_target, stack_pointer;
    logic [7:0] table_data;
    boag_pkg::boag_opnd_s opnd;
    int miscompares = 0;
    int check_count = 0;
    logic [4:0] n;

    // kind 0 branch, 1 address, 2 address and flags {ram,sfr,fault}, 3 register
    boag_row_s rows [18] = '{
        '{3'h1, 4'h0, 16'hC3A5, 8'h00, 3'h0, 1'b0, 0, 16'hC3A5, 3'h0},
        '{3'h3, 4'h0, 16'h0000, 8'h00, 3'h0, 1'b0, 0, 16'h1234, 3'h0},
        '{3'h0, 4'h1, 16'hFE00, 8'h00, 3'h0, 1'b0, 1, 16'hFE00, 3'h0},
        '{3'h0, 4'h2, 16'h0000, 8'h20, 3'h0, 1'b0, 2, 16'hFE20, 3'b100},
        '{3'h0, 4'h2, 16'h0000, 8'hFF, 3'h0, 1'b0, 2, 16'hFEFF, 3'b100},
        '{3'h0, 4'h2, 16'h0000, 8'h1F, 3'h0, 1'b0, 2, 16'hFF1F, 3'b010},
        '{3'h0, 4'h2, 16'h0000, 8'h00, 3'h0, 1'b0, 2, 16'hFF00, 3'b010},
        '{3'h0, 4'h2, 16'h0000, 8'h30, 3'h0, 1'b1, 2, 16'hFE30, 3'b100},
        '{3'h0, 4'h3, 16'h0000, 8'h00, 3'h0, 1'b0, 2, 16'hFF00, 3'b010},
        '{3'h0, 4'h3, 16'h0000, 8'hCF, 3'h0, 1'b0, 2, 16'hFFCF, 3'b010},
        '{3'h0, 4'h3, 16'h0000, 8'hE0, 3'h0, 1'b0, 2, 16'hFFE0, 3'b010},
        '{3'h0, 4'h3, 16'h0000, 8'h10, 3'h0, 1'b1, 2, 16'hFF10, 3'b011},
        '{3'h0, 4'h4, 16'h0000, 8'h00, 3'h5, 1'b0, 3, 16'h0005, 3'h0},
        '{3'h0, 4'h4, 16'h0000, 8'h00, 3'h6, 1'b1, 3, 16'h0004, 3'h0},
        '{3'h0, 4'h5, 16'h0000, 8'h00, 3'h0, 1'b0, 1, 16'hFE40, 3'h0},
        '{3'h0, 4'h6, 16'h0000, 8'h00, 3'h0, 1'b0, 1, 16'hFFF0, 3'h0},
        '{3'h0, 4'h7, 16'h0000, 8'h20, 3'h0, 1'b0, 1, 16'h0010, 3'h0},
        '{3'h0, 4'h7, 16'h0000, 8'h05, 3'h0, 1'b0, 1, 16'hFFF5, 3'h0}
    };

    boag_top i_boag_top (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req(req),
        .pairs(pairs), .sp_load(sp_load), .sp_value(sp_value), .irq_save(irq_save),
        .irq_restore(irq_restore), .busy(busy), .table_rd(table_rd),
        .table_addr(table_addr), .table_data(table_data), .pc_load(pc_load),
        .pc_target(pc_target), .opnd(opnd), .stack_pointer(stack_pointer));

    boag_mem_model i_boag_mem_model (.clk(clk), .table_rd(table_rd),
        .table_addr(table_addr), .table_data(table_data));

    always #25 clk = ~clk;

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one-cycle request; returns at the falling edge after it was taken
    task automatic issue(input boag_pkg::boag_req_s r);
        @(negedge clk);
        req = r;
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
    endtask

    // strobe order is {sp_load, irq_save, irq_restore}
    task automatic strobe(input logic [2:0] s, input logic [15:0] exp_sp);
        @(negedge clk);
        {sp_load, irq_save, irq_restore} = s;
        @(negedge clk);
        {sp_load, irq_save, irq_restore} = 3'b000;
        check("stack_pointer", stack_pointer, exp_sp);
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // about 70 cycles are needed; 2000 leaves ample room
    initial begin
        #100000;
        miscompares++;
        end_sim();
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (3) @(negedge clk);
        check("pc_target", pc_target, 16'h0000);
        check("opnd", {7'h00, opnd[24], opnd[7:0]}, 16'h0000);
        check("stack_pointer", stack_pointer, 16'hFEFF);
        check("busy", {13'h0, pc_load, busy, table_rd}, 16'h0000);
        sys_rst = 1'b0;
        $display("reset test done");

        foreach (rows[i]) begin
            issue({rows[i].br, rows[i].md, 8'h00, rows[i].i16, rows[i].i8,
                rows[i].code, rows[i].wide});
            if (rows[i].kind == 0) begin
                check("pc", {pc_load, pc_target[14:0]}, {1'b1, rows[i].exp[14:0]});
                check("pc_hi", {15'h0, pc_target[15]}, {15'h0, rows[i].exp[15]});
            end else if (rows[i].kind == 3) begin
                check("reg_sel", {12'h0, opnd.is_reg, opnd.reg_sel}, {13'h1, rows[i].exp[2:0]});
            end else begin
                check("addr", opnd.addr, rows[i].exp);
                check("valid", {15'h0, opnd.valid}, 16'h0001);
            end
            if (rows[i].kind == 2) begin
                check("flags", {13'h0, opnd.in_ram, opnd.in_sfr, opnd.fault}, {13'h0, rows[i].flg});
            end
            $display("row %0d done", i);
        end

        for (int k = 0; k < 2; k++) begin
            n = (k == 0) ? 5'd0 : 5'd31;
            issue({3'h2, 4'h0, 2'b00, n, 1'b0, 16'h0000, 8'h00, 3'h0, 1'b0});
            check("rd lo", {busy, table_rd, table_addr[13:0]}, {2'b11, 6'h00, 2'b01, n, 1'b0});
            @(negedge clk);
            check("rd hi", {busy, table_rd, table_addr[13:0]}, {2'b11, 6'h00, 2'b01, n, 1'b1});
            req = {3'h1, 4'h0, 8'h00, 16'h0BAD, 8'h00, 3'h0, 1'b0};
            req_valid = 1'b1;
            @(negedge clk);
            req_valid = 1'b0;
            check("table pc", pc_target, {3'b101, n, n, 3'b011});
            check("pc_load", {14'h0, pc_load, busy}, 16'h0002);
            @(negedge clk);
            check("refused", {15'h0, pc_load}, 16'h0000);
            $display("table test %0d done", n);
        end

        @(negedge clk);
        req = {3'h0, 4'h1, 8'h00, 16'h8001, 8'h00, 3'h0, 1'b0};
        req_valid = 1'b1;
        @(negedge clk);
        req = {3'h0, 4'h1, 8'h00, 16'h7FFE, 8'h00, 3'h0, 1'b0};
        check("first", opnd.addr, 16'h8001);
        @(negedge clk);
        req_valid = 1'b0;
        check("second", opnd.addr, 16'h7FFE);
        $display("back to back test done");

        issue({3'h0, 4'h0, 8'hAA, 16'h0000, 8'h00, 3'h0, 1'b0});
        check("push", opnd.addr, 16'hFEFD);
        check("sp push", stack_pointer, 16'hFEFD);
        issue({3'h0, 4'h9, 8'h00, 16'h0000, 8'h00, 3'h0, 1'b0});
        check("pop", opnd.addr, 16'hFEFD);
        check("sp pop", stack_pointer, 16'hFEFF);
        issue({3'h0, 4'h8, 8'h00, 16'h0000, 8'h00, 3'h0, 1'b0});
        check("push mode", opnd.addr, 16'hFEFD);
        check("push wide", {15'h0, opnd.wide}, 16'h0001);
        check("sp push mode", stack_pointer, 16'hFEFD);
        strobe(3'b001, 16'hFEFF);
        strobe(3'b010, 16'hFEFD);
        strobe(3'b001, 16'hFEFF);
        strobe(3'b100, 16'hFE80);
        $display("stack test done");

        @(negedge clk);
        sys_rst = 1'b1;
        @(negedge clk);
        check("sp rst", stack_pointer, 16'hFEFF);
        sys_rst = 1'b0;
        $display("second reset test done");
        end_sim();
    end
endmodule
`default_nettype wire
